// ==== verilog/cwr_pkg.sv ====
// constants shared by the clock watchdog and recovery block
package cwr_pkg;

  // register offsets on the byte-wide management port
  localparam logic [7:0] CWR_OFS_WDCTRL   = 8'h0b;
  localparam logic [7:0] CWR_OFS_CPU_LO   = 8'h0c;
  localparam logic [7:0] CWR_OFS_CPU_HI   = 8'h0d;
  localparam logic [7:0] CWR_OFS_GFX_LO   = 8'h0e;
  localparam logic [7:0] CWR_OFS_RECOV_LO = 8'h0f;
  localparam logic [7:0] CWR_OFS_OVERCLK  = 8'h10;

  // watchdog_control field positions
  localparam int CWR_WD_RECSRC  = 7;
  localparam int CWR_WD_ACTION  = 6;
  localparam int CWR_WD_SCALE   = 5;
  localparam int CWR_WD_FLAG    = 4;
  localparam int CWR_WD_TMR_HI  = 3;
  localparam int CWR_WD_TMR_LO  = 1;
  localparam int CWR_DOG_ENABLE      = 0;

  // cpu_divider_high field positions
  localparam int CWR_CPU_N8     = 7;
  localparam int CWR_CPU_M_HI   = 6;

  // overclocking support field positions
  localparam int CWR_OC_GFX_N8  = 7;
  localparam int CWR_OC_RATIO   = 6;
  localparam int CWR_OC_DYNF    = 5;
  localparam int CWR_OC_SRCPROG = 4;
  localparam int CWR_OC_GFXPROG = 3;
  localparam int CWR_OC_CPUPROG = 2;
  localparam int CWR_OC_AUTO    = 1;
  localparam int CWR_OC_SAFE_N8 = 0;

  // reset values
  localparam logic [7:0] CWR_RST_WDCTRL  = 8'h20;
  localparam logic [7:0] CWR_RST_DIVIDER = 8'h00;
  localparam logic [7:0] CWR_RST_OVERCLK = 8'h00;

  // timing
  localparam int CWR_CLK_KHZ        = 100000;
  localparam int CWR_SCALE_SHORT_MS = 294;
  localparam int CWR_SCALE_LONG_MS  = 2340;
  localparam int CWR_SHORT_CYCLES   = CWR_SCALE_SHORT_MS * CWR_CLK_KHZ;
  localparam int CWR_LONG_CYCLES    = CWR_SCALE_LONG_MS * CWR_CLK_KHZ;
  localparam int CWR_SYSTEM_RESET_OUT_CYCLES  = 16;
  localparam int CWR_UNIT_W         = 28;

  // timer states
  typedef enum logic [1:0] {
    CWR_IDLE   = 2'b00,
    CWR_COUNT  = 2'b01,
    CWR_EXPIRE = 2'b10
  } cwr_state_t;

endpackage

// ==== verilog/cwr_clock_watchdog_recovery.sv ====
// watchdog timer and frequency recovery of the clock synthesizer
// Notes on behaviour
// (R1) recovery source bit: 0 restores strapped settings, 1 restores stored nine-bit divider
// (R2) timeout asserts reset out; action 0 also reloads recovery, 1 reset only; in automatic mode code also drops cpu and graphics programming enables
// (R3) scale bit picks 294 ms (0) or 2.34 s (1) unit; powers up 1
// (R4) expiry flag set on timeout, cleared when host writes timeout field zero
// (R5) period is timeout field times unit; code 000 is test mode; the logic never starts the timer on 000 and only clears the flag
// (R6) writing enable 1 starts the timer loaded with selected period; 0 disables
// (R7) cpu programming enable selects programmed N and M dividers over hardware ones
// (R8) ratio override picks soft frequency select, else latched strap select
// (R9) graphics programming enable selects programmed nine-bit graphics N divider
// (R10) reset input or a timeout with action 0 loads recovery N; M reverts to strap value
// (R11) host stores a safe cpu divider before overclocking
// (R12) recovery divider msb lives in overclocking register bit 0, both recoveries
// (R13) autorecovery bit: 0 manual, 1 automatic
// (R14) falling edge of reset input returns every pll to safe frequency
// (R15) enabled timer counts units down; rewrite restarts; zero fires timeout
`timescale 1ns/1ps
module cwr_clock_watchdog_recovery
  import cwr_pkg::*;
#(
  parameter int SHORT_UNIT_CYCLES = CWR_SHORT_CYCLES,
  parameter int LONG_UNIT_CYCLES  = CWR_LONG_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // pins and host selections
  input  wire logic       resetIn_b,
  input  wire logic [2:0] strapFreqSelect,
  input  wire logic [2:0] softFreqSelect,
  // system reset pulse
  output logic            systemResetOut,
  // cpu pll setting
  output logic            cpuFeedbackOverride,
  output logic      [8:0] cpuFeedbackDiv,
  output logic            cpuRefOverride,
  output logic      [6:0] cpuRefDiv,
  output logic      [2:0] ratioSelect,
  // graphics pll setting
  output logic            graphicsDivOverride,
  output logic      [8:0] graphicsFeedbackDiv
);

  // reset release through two flops
  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  wire rstn = rstSync2_q;

  // pin synchronisers and reset input edge stage
  logic [2:0] resetInSync_q;
  logic [2:0] strapSync1_q;
  logic [2:0] strapSync2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resetInSync_q <= 3'h7;
      strapSync1_q  <= 3'h0;
      strapSync2_q  <= 3'h0;
    end else begin
      resetInSync_q <= {resetInSync_q[1:0], resetIn_b};
      strapSync1_q  <= strapFreqSelect;
      strapSync2_q  <= strapSync1_q;
    end
  end
  wire resetInFall = resetInSync_q[2] & ~resetInSync_q[1]; // R14

  // strap select sampled on the first three cycles after reset release, then held
  logic [1:0] strapWait_q;
  logic [2:0] strapLatched_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapWait_q    <= 2'h0;
      strapLatched_q <= 3'h0;
    end else if (strapWait_q != 2'h3) begin
      strapWait_q    <= strapWait_q + 2'h1;
      strapLatched_q <= strapSync2_q;
    end
  end

  // write decode
  wire wrWd   = regWrEn && (regAddr == CWR_OFS_WDCTRL);
  wire wrCpuL = regWrEn && (regAddr == CWR_OFS_CPU_LO);
  wire wrCpuH = regWrEn && (regAddr == CWR_OFS_CPU_HI);
  wire wrGfx  = regWrEn && (regAddr == CWR_OFS_GFX_LO);
  wire wrRec  = regWrEn && (regAddr == CWR_OFS_RECOV_LO);
  wire wrOc   = regWrEn && (regAddr == CWR_OFS_OVERCLK);
  wire [2:0] wrTmrField = regWrData[CWR_WD_TMR_HI:CWR_WD_TMR_LO];

  // register storage
  logic [7:0] wdCtrl_q;
  logic [7:0] cpuLo_q;
  logic [7:0] cpuHi_q;
  logic [7:0] gfxLo_q;
  logic [7:0] recLo_q;
  logic [7:0] overclk_q;
  logic       expiryFlag_q;
  logic       expirePulse;
  logic       autoRearm;

  // host writes to divider registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuLo_q <= CWR_RST_DIVIDER;
      cpuHi_q <= CWR_RST_DIVIDER;
      gfxLo_q <= CWR_RST_DIVIDER;
      recLo_q <= CWR_RST_DIVIDER;
    end else begin
      if (wrCpuL) cpuLo_q <= regWrData;
      if (wrCpuH) cpuHi_q <= regWrData;
      if (wrGfx)  gfxLo_q <= regWrData;
      if (wrRec)  recLo_q <= regWrData; // R11
    end
  end

  // overclocking register; automatic recovery drops programming enables
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overclk_q <= CWR_RST_OVERCLK;
    end else if (wrOc) begin
      overclk_q <= regWrData;
    end else if (autoRearm) begin
      overclk_q[CWR_OC_CPUPROG] <= 1'b0; // R13
      overclk_q[CWR_OC_GFXPROG] <= 1'b0;
    end
  end

  // watchdog control; flag bit is kept apart and only hardware sets it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdCtrl_q <= CWR_RST_WDCTRL; // R3
    end else if (wrWd) begin
      wdCtrl_q <= regWrData;
    end else if (expirePulse && !overclk_q[CWR_OC_AUTO]) begin
      wdCtrl_q[CWR_DOG_ENABLE] <= 1'b0; // manual mode stops after one timeout
    end
  end

  // expiry flag: a timeout in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      expiryFlag_q <= 1'b0;
    end else if (expirePulse) begin
      expiryFlag_q <= 1'b1; // R4
    end else if (wrWd && (wrTmrField == 3'h0)) begin
      expiryFlag_q <= 1'b0; // R4
    end
  end

  // timer control
  wire        wdEnable  = wdCtrl_q[CWR_DOG_ENABLE];
  wire [2:0]  tmrField  = wdCtrl_q[CWR_WD_TMR_HI:CWR_WD_TMR_LO];
  wire        startWr   = wrWd && regWrData[CWR_DOG_ENABLE] && (wrTmrField != 3'h0); // R6 R15
  wire        stopWr    = wrWd && !regWrData[CWR_DOG_ENABLE];
  wire        useLong   = wrWd ? regWrData[CWR_WD_SCALE] : wdCtrl_q[CWR_WD_SCALE];

  // one base unit in cycles less one, for the selected scale
  function automatic logic [CWR_UNIT_W-1:0] unitLoad(input logic longScale);
    int cycles;
    cycles   = longScale ? LONG_UNIT_CYCLES : SHORT_UNIT_CYCLES; // R3
    unitLoad = CWR_UNIT_W'(cycles - 1);
  endfunction

  cwr_state_t              state_q;
  cwr_state_t              state_d;
  logic [CWR_UNIT_W-1:0]   unitCnt_q;
  logic [2:0]              unitsLeft_q;
  wire                     unitDone = (unitCnt_q == '0);
  wire                     lastUnit = (unitsLeft_q == 3'h1);

  // timer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      CWR_IDLE:   if (startWr) state_d = CWR_COUNT;
      CWR_COUNT: begin
        if (stopWr)                      state_d = CWR_IDLE;
        else if (startWr)                state_d = CWR_COUNT;
        else if (unitDone && lastUnit)   state_d = CWR_EXPIRE; // R15
      end
      CWR_EXPIRE: begin
        if (startWr || (overclk_q[CWR_OC_AUTO] && wdEnable && tmrField != 3'h0)) begin
          state_d = CWR_COUNT;
        end else begin
          state_d = CWR_IDLE;
        end
      end
      default:    state_d = CWR_IDLE;
    endcase
  end

  assign expirePulse = (state_q == CWR_EXPIRE);
  assign autoRearm   = expirePulse && overclk_q[CWR_OC_AUTO];
  wire   reloadTimer = startWr || (expirePulse && state_d == CWR_COUNT);

  // base unit and unit countdown
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= CWR_IDLE;
      unitCnt_q   <= '0;
      unitsLeft_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (reloadTimer) begin
        unitCnt_q   <= unitLoad(useLong);
        unitsLeft_q <= wrWd ? wrTmrField : tmrField; // R5
      end else if (state_q == CWR_COUNT) begin
        if (unitDone) begin
          unitCnt_q   <= unitLoad(useLong);
          unitsLeft_q <= unitsLeft_q - 3'h1; // R15
        end else begin
          unitCnt_q <= unitCnt_q - CWR_UNIT_W'(1);
        end
      end
    end
  end

  // system reset pulse width
  logic [4:0] sresetCnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sresetCnt_q <= 5'h0;
    end else if (expirePulse) begin
      sresetCnt_q <= 5'(CWR_SYSTEM_RESET_OUT_CYCLES); // R2
    end else if (sresetCnt_q != 5'h0) begin
      sresetCnt_q <= sresetCnt_q - 5'h1;
    end
  end

  // recovery state, entered by reset input or a reloading timeout
  logic recovering_q;
  wire  recoverSet = resetInFall || (expirePulse && !wdCtrl_q[CWR_WD_ACTION]); // R2 R10 R14
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      recovering_q <= 1'b0;
    end else if (recoverSet) begin
      recovering_q <= 1'b1;
    end else if (wrOc) begin
      recovering_q <= 1'b0; // host reprograms to leave recovery
    end
  end

  // effective pll settings
  wire [8:0] progN    = {cpuHi_q[CWR_CPU_N8], cpuLo_q};
  wire [6:0] progM    = cpuHi_q[CWR_CPU_M_HI:0];
  wire [8:0] safeN    = {overclk_q[CWR_OC_SAFE_N8], recLo_q}; // R12
  wire [8:0] gfxN     = {overclk_q[CWR_OC_GFX_N8], gfxLo_q};
  wire       cpuProg  = overclk_q[CWR_OC_CPUPROG];
  wire       recSrc   = wdCtrl_q[CWR_WD_RECSRC];
  wire       nOvr_d   = recovering_q ? recSrc : cpuProg; // R1 R7 R10
  wire [8:0] nVal_d   = recovering_q ? safeN : progN; // R10
  wire       mOvr_d   = !recovering_q && cpuProg; // R10
  wire       gOvr_d   = !recovering_q && overclk_q[CWR_OC_GFXPROG]; // R9 R14
  wire       ratioSw  = !recovering_q && overclk_q[CWR_OC_RATIO];
  wire [2:0] ratio_d  = ratioSw ? softFreqSelect : strapLatched_q; // R8

  // read mux
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      CWR_OFS_WDCTRL:   rdMux = {wdCtrl_q[7:5], expiryFlag_q, wdCtrl_q[3:0]};
      CWR_OFS_CPU_LO:   rdMux = cpuLo_q;
      CWR_OFS_CPU_HI:   rdMux = cpuHi_q;
      CWR_OFS_GFX_LO:   rdMux = gfxLo_q;
      CWR_OFS_RECOV_LO: rdMux = recLo_q;
      CWR_OFS_OVERCLK:  rdMux = overclk_q;
      default:          rdMux = 8'h00;
    endcase
  end

  // output flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData           <= 8'h00;
      systemResetOut      <= 1'b0;
      cpuFeedbackOverride <= 1'b0;
      cpuFeedbackDiv      <= 9'h000;
      cpuRefOverride      <= 1'b0;
      cpuRefDiv           <= 7'h00;
      ratioSelect         <= 3'h0;
      graphicsDivOverride <= 1'b0;
      graphicsFeedbackDiv <= 9'h000;
    end else begin
      regRdData           <= rdMux;
      systemResetOut      <= (sresetCnt_q != 5'h0); // R2
      cpuFeedbackOverride <= nOvr_d;
      cpuFeedbackDiv      <= nVal_d;
      cpuRefOverride      <= mOvr_d;
      cpuRefDiv           <= progM;
      ratioSelect         <= ratio_d;
      graphicsDivOverride <= gOvr_d;
      graphicsFeedbackDiv <= gfxN;
    end
  end

endmodule

// ==== sim/cwr_host_model.sv ====
// host model driving the register port from the falling clock edge
`timescale 1ns/1ps
module cwr_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  // idle port at time zero
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
  end
  // one strobe cycle; data inverted once released so stale bytes never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk);
    regWrEn   = 1'b0;
    regWrData = ~d;
  endtask
  // address held a full cycle before the registered byte is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    d = regRdData;
  endtask
endmodule

// ==== sim/cwr_checker_assertions.sv ====
// port-level checks of the watchdog and recovery block
`timescale 1ns/1ps
module cwr_checker
  import cwr_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // register port and pins
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic       resetIn_b,
  input wire logic [2:0] softFreqSelect,
  // outputs watched
  input wire logic       systemResetOut,
  input wire logic       cpuRefOverride,
  input wire logic [6:0] cpuRefDiv,
  input wire logic [2:0] ratioSelect,
  input wire logic       graphicsDivOverride,
  input wire logic [8:0] graphicsFeedbackDiv
);
  logic actSel_q;
  // write decodes
  wire ocWr = regWrEn && regAddr == CWR_OFS_OVERCLK;
  wire mWr  = regWrEn && regAddr == CWR_OFS_CPU_HI;
  wire gWr  = ocWr || (regWrEn && regAddr == CWR_OFS_GFX_LO);
  // remembers the timeout action last chosen
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) actSel_q <= 1'b0;
    else if (regWrEn && regAddr == CWR_OFS_WDCTRL) actSel_q <= regWrData[CWR_WD_ACTION];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pulse_width_a: assert property ($rose(systemResetOut) |->
    systemResetOut[*8] ##1 systemResetOut[*8] ##1 !systemResetOut)
    else $error("bad reset pulse");
  m_stable_a: assert property ($changed(cpuRefDiv) |-> $past(mWr) || $past(mWr, 2))
    else $error("m divider moved unwritten");
  gfx_stable_a: assert property ($changed(graphicsFeedbackDiv) |->
    $past(gWr) || $past(gWr, 2)) else $error("graphics divider moved unwritten");
  cpu_prog_a: assert property (ocWr && regWrData[CWR_OC_CPUPROG] |-> ##[1:3] cpuRefOverride)
    else $error("cpu override not taken");
  gfx_prog_a: assert property (ocWr && regWrData[CWR_OC_GFXPROG] |->
    ##[1:3] graphicsDivOverride) else $error("graphics override not taken");
  ratio_soft_a: assert property (ocWr && regWrData[CWR_OC_RATIO] |->
    ##[1:3] ratioSelect == softFreqSelect) else $error("soft ratio not used");
  reload_safe_a: assert property ($rose(systemResetOut) && !actSel_q |->
    ##[0:4] !cpuRefOverride && !graphicsDivOverride) else $error("no reload on timeout");
  reset_only_a: assert property ($rose(systemResetOut) && actSel_q |->
    $stable(graphicsDivOverride)[*4]) else $error("reload on reset-only timeout");
  pin_recover_a: assert property ($fell(resetIn_b) |->
    ##[1:6] !cpuRefOverride && !graphicsDivOverride) else $error("no recovery on reset pin");
endmodule
bind cwr_clock_watchdog_recovery cwr_checker chk_i (
  .clk, .rst_b, .regAddr, .regWrEn, .regWrData, .resetIn_b, .softFreqSelect,
  .systemResetOut, .cpuRefOverride, .cpuRefDiv, .ratioSelect, .graphicsDivOverride,
  .graphicsFeedbackDiv
);

// ==== sim/cwr_clock_watchdog_recovery_tb_top.sv ====
// self-checking bench for the watchdog and recovery block
`timescale 1ns/1ps
module cwr_clock_watchdog_recovery_tb_top;
  import cwr_pkg::*;
  logic       clk, rst_b, resetIn_b, regWrEn, systemResetOut;
  logic       cpuFeedbackOverride, cpuRefOverride, graphicsDivOverride;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic [8:0] cpuFeedbackDiv, graphicsFeedbackDiv;
  logic [6:0] cpuRefDiv;
  logic [2:0] ratioSelect;
  int         failCount, comparisons, cyc, n;
  // short units keep the run brief
  cwr_clock_watchdog_recovery #(.SHORT_UNIT_CYCLES(20), .LONG_UNIT_CYCLES(50)) dut (
    .clk, .rst_b, .regAddr, .regWrEn, .regWrData, .regRdData, .resetIn_b,
    .strapFreqSelect(3'h3), .softFreqSelect(3'h5), .systemResetOut,
    .cpuFeedbackOverride, .cpuFeedbackDiv, .cpuRefOverride, .cpuRefDiv,
    .ratioSelect, .graphicsDivOverride, .graphicsFeedbackDiv
  );
  cwr_host_model host (.clk, .regAddr, .regWrEn, .regWrData, .regRdData);
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // read a register and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    chk("read", rdv, e);
  endtask
  // wait for the reset pulse, n counts cycles up to the limit
  task automatic waitRst(input int lim);
    n = 0;
    while (systemResetOut !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // let k falling edges pass
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask
  // counts, verdict and end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failCount++;
      results();
    end
  end
  // main sequence
  initial begin
    rst_b     = 1'b0;
    resetIn_b = 1'b1;
    idle(4);
    rst_b = 1'b1;
    idle(8);
    rc(CWR_OFS_WDCTRL, 8'h20);
    rc(CWR_OFS_CPU_LO, 8'h00);
    host.wr(8'h11, 8'hff);
    rc(8'h11, 8'h00);
    host.wr(CWR_OFS_WDCTRL, 8'h30);
    rc(CWR_OFS_WDCTRL, 8'h20);
    // safe divider stored before overclocking
    host.wr(CWR_OFS_RECOV_LO, 8'ha5);
    host.wr(CWR_OFS_CPU_LO, 8'h34);
    host.wr(CWR_OFS_CPU_HI, 8'hc5);
    host.wr(CWR_OFS_GFX_LO, 8'h77);
    host.wr(CWR_OFS_OVERCLK, 8'h4d);
    rc(CWR_OFS_CPU_HI, 8'hc5);
    chk("cpu", {cpuFeedbackOverride, cpuFeedbackDiv, cpuRefOverride, cpuRefDiv}, 18'h334c5);
    chk("gfx", {graphicsDivOverride, graphicsFeedbackDiv}, 10'h277);
    chk("ratio", ratioSelect, 3'h5);
    // timeout with reload, short scale, two units
    host.wr(CWR_OFS_WDCTRL, 8'h85);
    waitRst(300);
    chk("period", n >= 36 && n <= 46, 1);
    idle(4);
    chk("recover", {cpuFeedbackOverride, cpuFeedbackDiv, cpuRefOverride,
                    graphicsDivOverride, ratioSelect}, 15'h74a3);
    rc(CWR_OFS_WDCTRL, 8'h94);
    idle(20);
    host.wr(CWR_OFS_WDCTRL, 8'h80);
    rc(CWR_OFS_WDCTRL, 8'h80);
    // reset only, long scale, one unit
    host.wr(CWR_OFS_OVERCLK, 8'h08);
    host.wr(CWR_OFS_WDCTRL, 8'h63);
    waitRst(300);
    chk("scale", n >= 46 && n <= 56, 1);
    idle(4);
    chk("only", graphicsDivOverride, 1);
    idle(20);
    host.wr(CWR_OFS_WDCTRL, 8'h01);
    waitRst(100);
    chk("test", n, 100);
    host.wr(CWR_OFS_WDCTRL, 8'h05);
    host.wr(CWR_OFS_WDCTRL, 8'h04);
    waitRst(100);
    chk("off", n, 100);
    // reset pin with programmed cpu and graphics settings selected
    host.wr(CWR_OFS_WDCTRL, 8'h00);
    host.wr(CWR_OFS_OVERCLK, 8'h0c);
    idle(3);
    resetIn_b = 1'b0;
    idle(8);
    chk("pin", {cpuFeedbackOverride, cpuRefOverride, graphicsDivOverride}, 3'h0);
    resetIn_b = 1'b1;
    // automatic mode reruns the timer
    host.wr(CWR_OFS_OVERCLK, 8'h02);
    host.wr(CWR_OFS_WDCTRL, 8'h03);
    waitRst(100);
    idle(20);
    waitRst(100);
    chk("auto", n < 60, 1);
    results();
  end
endmodule
